//--- design/plmc_regs.svh
/*
 * Register offsets, field positions, reset values and timing constants
 * for the LED and miscellaneous PHY configuration bank.
 * Assumes a 20 MHz system clock and a 32-bit Avalon-MM word bus.
 */
`ifndef PLMC_REGS_SVH
`define PLMC_REGS_SVH

// register indices; byte address is four times the index
`define PLMC_LED_IDX 6'h19
`define PLMC_BLINK_IDX 6'h1a
`define PLMC_MISC_IDX 6'h1e
`define PLMC_STS_IDX 6'h20
`define PLMC_MASK_IDX 6'h21

`define PLMC_LED_RST 16'h4444
`define PLMC_BLINK_RST 16'h0002
`define PLMC_MISC_RST 16'h0012
`define PLMC_LED_WMASK 16'h7777
`define PLMC_BLINK_WMASK 16'h0007
`define PLMC_MISC_WMASK 16'hfff8

// per-led nibble: led n at bit 4*n, aux led is n = 3
`define PLMC_LED_EN_OFS 0
`define PLMC_LED_VAL_OFS 1
`define PLMC_LED_POL_OFS 2

`define PLMC_BYPASS_BIT 2
`define PLMC_RATE_LSB 0

`define PLMC_QNEG_EN_BIT 14
`define PLMC_QNEG_SEL_LSB 12
`define PLMC_PD_FD_BIT 11
`define PLMC_RST_STS_BIT 10
`define PLMC_ROBUST_BIT 9
`define PLMC_QXOVER_BIT 8
`define PLMC_INT_OE_BIT 7
`define PLMC_FORCE_INT_BIT 6
`define PLMC_GIG_NEG_BIT 3
`define PLMC_FAIL_BIT 2
`define PLMC_DONE_BIT 1
`define PLMC_LAUNCH_BIT 0

`define PLMC_EV_DONE 0
`define PLMC_EV_FAIL 1

`define PLMC_CLK_NS 50
`define PLMC_MS_NS 1000000
`define PLMC_BLINK0_MS 50
`define PLMC_BLINK1_MS 100
`define PLMC_BLINK2_MS 200
`define PLMC_BLINK3_MS 500
`define PLMC_STRETCH_MS 50

`endif

//--- design/plmc_pkg.sv
/*
 * Types for the LED and miscellaneous PHY configuration bank.
 * Assumes plmc_regs.svh supplies all numeric constants.
 */
package plmc_pkg;

   typedef enum logic {TEST_IDLE, TEST_RUN} plmc_test_e;

   typedef struct packed {
      logic quick_neg_en;
      logic [1:0] quick_neg_sel;
      logic pd_full_duplex;
      logic robust_xover;
      logic quick_xover;
      logic gig_forced_neg;
   } plmc_cfg_s;

   typedef struct packed {
      logic [15:0] led_reg;
      logic [15:0] blink_reg;
      logic [15:0] misc_reg;
      logic [1:0] sts_reg;
      logic [1:0] mask_reg;
      logic ack;
      logic [15:0] rdata;
      logic [15:0] div;
      logic [8:0] blink_ms;
      logic phase;
      logic [3:0][5:0] stretch;
      logic [3:0] leds;
      logic pad_meta;
      logic pad_sync;
      plmc_test_e test;
      logic start_pulse;
      logic clr_pulse;
   } plmc_state_s;

endpackage

//--- design/plmc_top.sv
/*
 * LED polarity/force/blink control and miscellaneous PHY configuration
 * registers behind an Avalon-MM slave with waitrequest, plus cable-test
 * handshake and the shared interrupt/power-down pad.
 * Assumes led_event, led_blink_req, phy_irq, restart_pulse and the
 * cable-test inputs come from logic on sys_clk; the pad input is async.
 */
`timescale 1ns/1ps
`include "plmc_regs.svh"

// Operation
// - per-led polarity bit, default active high
// - aux led forced to bit 13 when bit 12
// - led2 forced to bit 9 when bit 8
// - led1 forced to bit 5 when bit 4
// - led0 forced to bit 1 when bit 0
// - blink field picks 50/100/200/500 ms period
// - stretch bypass makes leds follow events
// - quick negotiation timer select when enabled
// - parallel detect declares full duplex
// - clear phy status on restart when enabled
// - robust crossover resolution enable
// - quick crossover mode enable
// - pad is power-down input or interrupt output
// - force bit asserts interrupt pad
// - manual 1G plus bit 3 runs negotiation
module plmc_top #(
   parameter int MS_CYCLES = `PLMC_MS_NS / `PLMC_CLK_NS
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [3:0] led_event,
   input wire logic [3:0] led_blink_req,
   output logic [3:0] led_pin,
   input wire logic manual_speed_1g,
   input wire logic restart_pulse,
   input wire logic phy_irq,
   input wire logic cable_test_done_in,
   input wire logic cable_test_fail_in,
   input wire logic irq_powerdown_pad_in,
   output logic irq_powerdown_pad_out,
   output logic irq_powerdown_pad_oe_n,
   output logic powerdown_req,
   output plmc_pkg::plmc_cfg_s cfg,
   output logic cable_test_start,
   output logic status_clear,
   output logic irq
);

   localparam plmc_pkg::plmc_state_s S_RST = '{
      led_reg: `PLMC_LED_RST,
      blink_reg: `PLMC_BLINK_RST,
      misc_reg: `PLMC_MISC_RST,
      sts_reg: 2'h0,
      mask_reg: 2'h0,
      ack: 1'b0,
      rdata: 16'h0000,
      div: 16'h0000,
      blink_ms: 9'h000,
      phase: 1'b0,
      stretch: 24'h00_0000,
      leds: 4'h0,
      pad_meta: 1'b1,
      pad_sync: 1'b1,
      test: plmc_pkg::TEST_IDLE,
      start_pulse: 1'b0,
      clr_pulse: 1'b0
   };

   plmc_pkg::plmc_state_s s_reg;
   plmc_pkg::plmc_state_s s_next;

   function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
      return (addr[7:2] == idx) && (addr[1:0] == 2'h0);
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] wd,
                                         input logic [1:0] be,
                                         input logic [15:0] wmask);
      logic [15:0] bm;
      bm = {{8{be[1]}}, {8{be[0]}}} & wmask;
      return (old & ~bm) | (wd & bm);
   endfunction

   // half of the blink period, in ms
   function automatic logic [8:0] half_ms(input logic [1:0] rate);
      logic [8:0] h;
      unique case (rate)
         2'h0: h = 9'(`PLMC_BLINK0_MS / 2);
         2'h1: h = 9'(`PLMC_BLINK1_MS / 2);
         2'h2: h = 9'(`PLMC_BLINK2_MS / 2);
         2'h3: h = 9'(`PLMC_BLINK3_MS / 2);
      endcase
      return h;
   endfunction

   logic req;
   logic wr;
   logic tick;
   logic [8:0] half;
   logic bypass;
   logic launch;
   logic [1:0] ev;

   assign req = avs_read | avs_write;
   assign wr = avs_write & s_reg.ack;
   assign tick = s_reg.div == 16'(MS_CYCLES - 1);
   assign half = half_ms(s_reg.blink_reg[`PLMC_RATE_LSB +: 2]);
   assign bypass = s_reg.blink_reg[`PLMC_BYPASS_BIT];
   assign launch = wr && hit(avs_address, `PLMC_MISC_IDX) && avs_byteenable[0]
                   && avs_writedata[`PLMC_LAUNCH_BIT];

   always_comb begin
      logic normal;
      logic lvl;
      logic [3:0] nib;
      normal = 1'b0;
      lvl = 1'b0;
      nib = 4'h0;
      s_next = s_reg;
      ev = 2'h0;
      s_next.start_pulse = 1'b0;

      // bus answer one cycle after the request
      s_next.ack = req & ~s_reg.ack;
      if (avs_read && !s_reg.ack) begin
         if (hit(avs_address, `PLMC_LED_IDX)) begin
            s_next.rdata = s_reg.led_reg;
         end else if (hit(avs_address, `PLMC_BLINK_IDX)) begin
            s_next.rdata = s_reg.blink_reg;
         end else if (hit(avs_address, `PLMC_MISC_IDX)) begin
            s_next.rdata = s_reg.misc_reg;
         end else if (hit(avs_address, `PLMC_STS_IDX)) begin
            s_next.rdata = {14'h0000, s_reg.sts_reg};
         end else if (hit(avs_address, `PLMC_MASK_IDX)) begin
            s_next.rdata = {14'h0000, s_reg.mask_reg};
         end else begin
            s_next.rdata = 16'h0000;
         end
      end

      if (wr) begin
         if (hit(avs_address, `PLMC_LED_IDX)) begin
            s_next.led_reg = merge(s_reg.led_reg, avs_writedata[15:0],
                                   avs_byteenable[1:0], `PLMC_LED_WMASK);
         end
         if (hit(avs_address, `PLMC_BLINK_IDX)) begin
            s_next.blink_reg = merge(s_reg.blink_reg, avs_writedata[15:0],
                                     avs_byteenable[1:0], `PLMC_BLINK_WMASK);
         end
         if (hit(avs_address, `PLMC_MISC_IDX)) begin
            s_next.misc_reg = merge(s_reg.misc_reg, avs_writedata[15:0],
                                    avs_byteenable[1:0], `PLMC_MISC_WMASK);
         end
         if (hit(avs_address, `PLMC_MASK_IDX) && avs_byteenable[0]) begin
            s_next.mask_reg = avs_writedata[1:0];
         end
      end

      unique case (s_reg.test)
         plmc_pkg::TEST_IDLE: begin
            if (launch) begin
               s_next.test = plmc_pkg::TEST_RUN;
               s_next.start_pulse = 1'b1;
               s_next.misc_reg[`PLMC_LAUNCH_BIT] = 1'b1;
               s_next.misc_reg[`PLMC_DONE_BIT] = 1'b0;
               s_next.misc_reg[`PLMC_FAIL_BIT] = 1'b0;
            end
         end
         plmc_pkg::TEST_RUN: begin
            if (cable_test_done_in) begin
               s_next.test = plmc_pkg::TEST_IDLE;
               s_next.misc_reg[`PLMC_LAUNCH_BIT] = 1'b0;
               s_next.misc_reg[`PLMC_DONE_BIT] = 1'b1;
               s_next.misc_reg[`PLMC_FAIL_BIT] = cable_test_fail_in;
               ev[`PLMC_EV_DONE] = 1'b1;
               ev[`PLMC_EV_FAIL] = cable_test_fail_in;
            end
         end
      endcase

      // sticky events, set wins over write-one-clear
      s_next.sts_reg = s_reg.sts_reg | ev;
      if (wr && hit(avs_address, `PLMC_STS_IDX) && avs_byteenable[0]) begin
         s_next.sts_reg = (s_reg.sts_reg & ~avs_writedata[1:0]) | ev;
      end

      s_next.clr_pulse = restart_pulse & s_reg.misc_reg[`PLMC_RST_STS_BIT];

      s_next.div = tick ? 16'h0000 : 16'(s_reg.div + 16'h0001);

      if (tick) begin
         if (s_reg.blink_ms >= half - 9'h001) begin
            s_next.blink_ms = 9'h000;
            s_next.phase = ~s_reg.phase;
         end else begin
            s_next.blink_ms = 9'(s_reg.blink_ms + 9'h001);
         end
      end

      for (int i = 0; i < 4; i++) begin
         nib = s_reg.led_reg[4*i +: 4];
         if (led_event[i]) begin
            s_next.stretch[i] = 6'(`PLMC_STRETCH_MS);
         end else if (tick && s_reg.stretch[i] != 6'h00) begin
            s_next.stretch[i] = 6'(s_reg.stretch[i] - 6'h01);
         end
         normal = bypass ? led_event[i] : (led_event[i] | (s_reg.stretch[i] != 6'h00));
         lvl = led_blink_req[i] ? (normal & s_reg.phase) : normal;
         if (nib[`PLMC_LED_EN_OFS]) begin
            lvl = nib[`PLMC_LED_VAL_OFS];
         end
         s_next.leds[i] = nib[`PLMC_LED_POL_OFS] ? lvl : ~lvl;
      end

      s_next.pad_meta = irq_powerdown_pad_in;
      s_next.pad_sync = s_reg.pad_meta;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s_reg <= S_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign avs_waitrequest = req & ~s_reg.ack;
   assign avs_readdata = {16'h0000, s_reg.rdata};
   assign led_pin = s_reg.leds;
   assign cable_test_start = s_reg.start_pulse;
   assign status_clear = s_reg.clr_pulse;
   assign irq = |(s_reg.sts_reg & s_reg.mask_reg);

   assign cfg.quick_neg_en = s_reg.misc_reg[`PLMC_QNEG_EN_BIT];
   assign cfg.quick_neg_sel = s_reg.misc_reg[`PLMC_QNEG_SEL_LSB +: 2];
   assign cfg.pd_full_duplex = s_reg.misc_reg[`PLMC_PD_FD_BIT];
   assign cfg.robust_xover = s_reg.misc_reg[`PLMC_ROBUST_BIT];
   assign cfg.quick_xover = s_reg.misc_reg[`PLMC_QXOVER_BIT];
   assign cfg.gig_forced_neg = manual_speed_1g & s_reg.misc_reg[`PLMC_GIG_NEG_BIT];

   assign irq_powerdown_pad_oe_n = ~(s_reg.misc_reg[`PLMC_INT_OE_BIT]
                                     | s_reg.misc_reg[`PLMC_FORCE_INT_BIT]);
   assign irq_powerdown_pad_out = ~(s_reg.misc_reg[`PLMC_FORCE_INT_BIT] | phy_irq | irq);
   assign powerdown_req = ~s_reg.misc_reg[`PLMC_INT_OE_BIT] & ~s_reg.pad_sync;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   chk_led0_low_force: assert property (
      s_reg.led_reg[0] && !s_reg.led_reg[2] |=> led_pin[0] == !$past(s_reg.led_reg[1]))
      else $error("led0 active-low force wrong");
   chk_led0_force: assert property (
      s_reg.led_reg[0] && s_reg.led_reg[2] |=> led_pin[0] == $past(s_reg.led_reg[1]))
      else $error("led0 force value wrong");
   chk_led1_force: assert property (
      s_reg.led_reg[4] && s_reg.led_reg[6] |=> led_pin[1] == $past(s_reg.led_reg[5]))
      else $error("led1 force value wrong");
   chk_led2_force: assert property (
      s_reg.led_reg[8] && s_reg.led_reg[10] |=> led_pin[2] == $past(s_reg.led_reg[9]))
      else $error("led2 force value wrong");
   chk_aux_led_force: assert property (
      s_reg.led_reg[12] && s_reg.led_reg[14] |=> led_pin[3] == $past(s_reg.led_reg[13]))
      else $error("aux led force value wrong");
   chk_stretch_bypass: assert property (
      bypass && !s_reg.led_reg[0] && s_reg.led_reg[2] && !led_blink_req[0]
      |=> led_pin[0] == $past(led_event[0]))
      else $error("bypassed led0 not following event");
   chk_blink_toggle: assert property (
      tick && s_reg.blink_ms >= half - 9'h001 |=> s_reg.phase != $past(s_reg.phase)
      && s_reg.blink_ms == 9'h000)
      else $error("blink phase missed half period");
   chk_restart_clear: assert property (
      restart_pulse && s_reg.misc_reg[10] |=> status_clear
      ##1 (!status_clear || $past(restart_pulse && s_reg.misc_reg[10])))
      else $error("status clear not pulsed");
   chk_pad_direction: assert property (
      s_reg.misc_reg[7] |-> !irq_powerdown_pad_oe_n && !powerdown_req)
      else $error("pad not driven as interrupt");
   chk_force_int: assert property (
      s_reg.misc_reg[6] |-> !irq_powerdown_pad_oe_n && !irq_powerdown_pad_out)
      else $error("forced interrupt not on pad");
   chk_gig_negotiation: assert property (
      cfg.gig_forced_neg == (manual_speed_1g && s_reg.misc_reg[3]))
      else $error("1G negotiation request wrong");
   chk_launch_start: assert property (
      launch && s_reg.test == plmc_pkg::TEST_IDLE |=> s_reg.misc_reg[0] && cable_test_start
      && !s_reg.misc_reg[1] ##1 !cable_test_start)
      else $error("cable test launch not taken");
   chk_test_done: assert property (
      s_reg.test == plmc_pkg::TEST_RUN && cable_test_done_in
      |=> !s_reg.misc_reg[0] && s_reg.misc_reg[1] && s_reg.sts_reg[0]
      && s_reg.misc_reg[2] == $past(cable_test_fail_in))
      else $error("cable test completion flags wrong");
   chk_launch_refused: assert property (
      launch && s_reg.test == plmc_pkg::TEST_RUN |=> !cable_test_start)
      else $error("launch taken while test running");
   chk_launch_held: assert property (
      s_reg.test == plmc_pkg::TEST_RUN && !cable_test_done_in |=> s_reg.misc_reg[0])
      else $error("launch bit dropped before completion");
   chk_idle_launch_low: assert property (
      s_reg.test == plmc_pkg::TEST_IDLE |-> !s_reg.misc_reg[0])
      else $error("launch bit set while idle");
   chk_flags_stable: assert property (
      s_reg.test == plmc_pkg::TEST_IDLE && !launch |=> $stable(s_reg.misc_reg[2:1]))
      else $error("done or fail flag changed without a test");

   chk_led1_low_force: assert property (
      s_reg.led_reg[4] && !s_reg.led_reg[6] |=> led_pin[1] == !$past(s_reg.led_reg[5]))
      else $error("led1 active-low force wrong");
   chk_led2_low_force: assert property (
      s_reg.led_reg[8] && !s_reg.led_reg[10] |=> led_pin[2] == !$past(s_reg.led_reg[9]))
      else $error("led2 active-low force wrong");
   chk_aux_low_force: assert property (
      s_reg.led_reg[12] && !s_reg.led_reg[14] |=> led_pin[3] == !$past(s_reg.led_reg[13]))
      else $error("aux led active-low force wrong");
   chk_led1_follow: assert property (
      bypass && !s_reg.led_reg[4] && s_reg.led_reg[6] && !led_blink_req[1]
      |=> led_pin[1] == $past(led_event[1]))
      else $error("unforced led1 not following event");
   chk_led2_follow: assert property (
      bypass && !s_reg.led_reg[8] && s_reg.led_reg[10] && !led_blink_req[2]
      |=> led_pin[2] == $past(led_event[2]))
      else $error("unforced led2 not following event");
   chk_aux_follow: assert property (
      bypass && !s_reg.led_reg[12] && s_reg.led_reg[14] && !led_blink_req[3]
      |=> led_pin[3] == $past(led_event[3]))
      else $error("unforced aux led not following event");
   chk_led0_active_low: assert property (
      bypass && !s_reg.led_reg[0] && !s_reg.led_reg[2] && !led_blink_req[0]
      |=> led_pin[0] == !$past(led_event[0]))
      else $error("active-low led0 not inverted");
   chk_stretch_load: assert property (
      led_event[0] |=> s_reg.stretch[0] == 6'(`PLMC_STRETCH_MS))
      else $error("led0 stretch not reloaded");
   chk_stretch_hold: assert property (
      !bypass && s_reg.led_reg[2:0] == 3'h4 && !led_blink_req[0]
      && s_reg.stretch[0] != 6'h00 |=> led_pin[0])
      else $error("stretched led0 dropped early");

   chk_pad_input: assert property (
      !s_reg.misc_reg[7] && !s_reg.misc_reg[6] |-> irq_powerdown_pad_oe_n)
      else $error("pad driven while power-down input");
   chk_powerdown_sync: assert property (
      !s_reg.misc_reg[7] |-> powerdown_req == !$past(irq_powerdown_pad_in, 2))
      else $error("power-down request not two-stage synced");
   chk_clear_kept: assert property (
      !s_reg.misc_reg[10] |=> !status_clear)
      else $error("status clear without enable");

endmodule

//--- bench/test_plmc_top.sv
/*
 * Self-checking bench for the LED and misc PHY configuration bank.
 * Assumes plmc_top with MS_CYCLES shortened to 4 and a 20 MHz clock.
 */
`timescale 1ns/1ps
`include "plmc_regs.svh"
module test_plmc_top;
   localparam int MS = 4;
   localparam logic [7:0] A_LED = {`PLMC_LED_IDX, 2'b00};
   localparam logic [7:0] A_BLK = {`PLMC_BLINK_IDX, 2'b00};
   localparam logic [7:0] A_MSC = {`PLMC_MISC_IDX, 2'b00};
   localparam logic [7:0] A_STS = {`PLMC_STS_IDX, 2'b00};
   localparam logic [7:0] A_MSK = {`PLMC_MASK_IDX, 2'b00};
   logic sys_clk, rstn, avs_read, avs_write, spd, rst_p, phy_irq, td, tf, pad_in;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable, led_event, blink_req, led_pin;
   logic avs_waitrequest, pad_out, pad_oe_n, pd_req, t_start, st_clr, irq;
   plmc_pkg::plmc_cfg_s cfg;
   int num_errors = 0;
   int n_checks = 0;
   int n_start = 0;
   int n_clr = 0;
   plmc_top #(.MS_CYCLES(MS)) i_dut (.sys_clk(sys_clk), .rstn(rstn),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .led_event(led_event), .led_blink_req(blink_req), .led_pin(led_pin),
      .manual_speed_1g(spd), .restart_pulse(rst_p), .phy_irq(phy_irq),
      .cable_test_done_in(td), .cable_test_fail_in(tf),
      .irq_powerdown_pad_in(pad_in), .irq_powerdown_pad_out(pad_out),
      .irq_powerdown_pad_oe_n(pad_oe_n), .powerdown_req(pd_req), .cfg(cfg),
      .cable_test_start(t_start), .status_clear(st_clr), .irq(irq));
   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (t_start === 1'b1) n_start++;
      if (st_clr === 1'b1) n_clr++;
   end
   task automatic results();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   // one request, held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                      output logic [31:0] q);
      int i;
      logic w;
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_byteenable <= 4'hf;
      avs_write <= wr;
      avs_read <= ~wr;
      w = 1'b1;
      for (i = 0; i < 20 && w !== 1'b0; i++) begin
         @(posedge sys_clk);
         w = avs_waitrequest;
         q = avs_readdata;
      end
      if (w !== 1'b0) begin
         num_errors++;
         $display("BAD waitrequest exp 0 got %b", w);
         results();
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      logic [31:0] q;
      bus(1'b0, a, 16'h0000, q);
      check("readdata", {16'h0000, e}, q);
   endtask
   localparam int P_LED = 0;
   localparam int P_CFG = 1;
   localparam int P_CLR = 2;
   localparam int P_PD = 3;
   localparam int P_PAD = 4;
   // value of the watched result at the moment it is read
   function automatic logic [31:0] probe(input int sel);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (sel)
         P_LED: v = 32'(led_pin);
         P_CFG: v = 32'(cfg);
         P_CLR: v = n_clr;
         P_PD: v = 32'(pd_req);
         default: v = 32'(pad_out);
      endcase
      return v;
   endfunction
   task automatic sample(input int n, input string what, input logic [31:0] e,
                         input int sel);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
      check(what, e, probe(sel));
      @(posedge sys_clk);
   endtask
   task automatic rise(output int n);
      logic p;
      int i;
      n = 0;
      p = led_pin[0];
      for (i = 0; i < 2100; i++) begin
         @(negedge sys_clk);
         n++;
         if (p === 1'b0 && led_pin[0] === 1'b1) break;
         p = led_pin[0];
      end
      if (i == 2100) begin
         num_errors++;
         $display("BAD blink edge exp rise got none");
         results();
      end
      @(posedge sys_clk);
   endtask
   task automatic t_regs();
      rd(A_LED, `PLMC_LED_RST);
      rd(A_BLK, `PLMC_BLINK_RST);
      rd(A_MSC, `PLMC_MISC_RST);
      rd(A_STS, 16'h0000);
      rd(A_MSK, 16'h0000);
      wr(A_LED, 16'hffff);
      rd(A_LED, `PLMC_LED_WMASK);
      wr(A_BLK, 16'hffff);
      rd(A_BLK, `PLMC_BLINK_WMASK);
      wr(A_MSC, 16'hfff8);
      rd(A_MSC, 16'hfffa);
      wr(8'h40, 16'hffff);
      rd(8'h40, 16'h0000);
      rd(8'h65, 16'h0000);
      wr(A_MSC, 16'h0000);
   endtask
   task automatic t_force();
      logic [15:0] v[3] = '{16'h3333, 16'h7777, 16'h7351};
      logic [3:0] e[3] = '{4'h0, 4'hf, 4'h9};
      int i;
      wr(A_BLK, 16'h0006);
      for (i = 0; i < 3; i++) begin
         wr(A_LED, v[i]);
         sample(4, "forced pins", e[i], P_LED);
      end
      led_event <= 4'ha;
      wr(A_LED, `PLMC_LED_RST);
      sample(4, "normal pins", 4'ha, P_LED);
      wr(A_LED, 16'h0000);
      sample(4, "active low pins", 4'h5, P_LED);
      led_event <= 4'h0;
      wr(A_LED, `PLMC_LED_RST);
   endtask
   task automatic t_stretch();
      wr(A_BLK, 16'h0002);
      // let stretching left from earlier events run out
      repeat (55 * MS) @(posedge sys_clk);
      led_event <= 4'h2;
      @(posedge sys_clk);
      led_event <= 4'h0;
      sample(40 * MS, "stretched", 4'h2, P_LED);
      sample(25 * MS, "stretch end", 4'h0, P_LED);
      wr(A_BLK, 16'h0006);
      led_event <= 4'h2;
      @(posedge sys_clk);
      led_event <= 4'h0;
      sample(6, "bypassed", 4'h0, P_LED);
   endtask
   task automatic t_blink();
      int ms[4] = '{`PLMC_BLINK0_MS, `PLMC_BLINK1_MS, `PLMC_BLINK2_MS, `PLMC_BLINK3_MS};
      int r;
      int n;
      led_event <= 4'h1;
      blink_req <= 4'h1;
      for (r = 0; r < 4; r++) begin
         wr(A_BLK, 16'h0004 | 16'(r));
         rise(n);
         rise(n);
         check("blink period", 1, (n >= ms[r] * MS - 2 && n <= ms[r] * MS + 2));
      end
      led_event <= 4'h0;
      blink_req <= 4'h0;
   endtask
   task automatic t_cfg();
      spd <= 1'b1;
      wr(A_MSC, 16'h6b08);
      sample(0, "cfg all", 7'b1101111, P_CFG);
      spd <= 1'b0;
      wr(A_MSC, 16'h1408);
      sample(0, "cfg sel", 7'b0010000, P_CFG);
   endtask
   task automatic t_restart();
      int c;
      c = n_clr;
      rst_p <= 1'b1;
      @(posedge sys_clk);
      rst_p <= 1'b0;
      sample(3, "status clear", c + 1, P_CLR);
      wr(A_MSC, 16'h0000);
      rst_p <= 1'b1;
      @(posedge sys_clk);
      rst_p <= 1'b0;
      sample(3, "status kept", c + 1, P_CLR);
   endtask
   task automatic t_cable();
      wr(A_MSK, 16'h0003);
      wr(A_MSC, 16'h0001);
      rd(A_MSC, 16'h0001);
      wr(A_MSC, 16'h0001);
      check("start pulses", 1, n_start);
      td <= 1'b1;
      tf <= 1'b1;
      @(posedge sys_clk);
      td <= 1'b0;
      tf <= 1'b0;
      rd(A_MSC, 16'h0006);
      rd(A_STS, 16'h0003);
      check("irq set", 1, irq);
      wr(A_MSK, 16'h0000);
      check("irq masked", 0, irq);
      wr(A_MSK, 16'h0001);
      check("irq unmasked", 1, irq);
      wr(A_STS, 16'h0001);
      check("irq cleared", 0, irq);
      rd(A_STS, 16'h0002);
      wr(A_STS, 16'h0002);
      rd(A_STS, 16'h0000);
   endtask
   task automatic t_pad();
      wr(A_MSC, 16'h0000);
      pad_in <= 1'b0;
      sample(3, "powerdown req", 1, P_PD);
      check("pad released", 1, pad_oe_n);
      wr(A_MSC, 16'h0080);
      phy_irq <= 1'b1;
      sample(3, "no powerdown", 0, P_PD);
      check("pad driven", 0, pad_oe_n);
      check("pad irq", 0, pad_out);
      phy_irq <= 1'b0;
      sample(0, "pad idle", 1, P_PAD);
      wr(A_MSC, 16'h0040);
      check("forced pad oe", 0, pad_oe_n);
      check("forced pad", 0, pad_out);
      pad_in <= 1'b1;
   endtask
   initial begin
      sys_clk = 1'b0;
      rstn = 1'b0;
      {avs_read, avs_write, spd, rst_p, phy_irq, td, tf} = 7'h00;
      pad_in = 1'b1;
      avs_address = 8'h00;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'h0;
      led_event = 4'h0;
      blink_req = 4'h0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      t_regs();
      t_force();
      t_stretch();
      t_blink();
      t_cfg();
      t_restart();
      t_cable();
      t_pad();
      results();
   end
endmodule
